// *** common/p4m_map.svh ***
// register offsets, reset values, field positions and synchroniser reset level for the port 4 block
// assumes inclusion by bare name from the design files
`ifndef P4M_MAP_SVH
`define P4M_MAP_SVH
`define P4M_ADDR_DATA      16'hffd7
`define P4M_ADDR_DIR       16'hffe7
`define P4M_RST_DATA       8'hf8
`define P4M_RST_DIR        8'hf8
`define P4M_FIXED_MASK     8'hf8
`define P4M_RW_MASK        8'h07
`define P4M_DIR_READ       8'hff
`define P4M_BIT_INTERNAL   3
`define P4M_BIT_TXD        2
`define P4M_BIT_RXD        1
`define P4M_BIT_SCK        0
`define P4M_SYNC_RST       1'b1
`endif

// *** common/p4m_pkg.sv ***
// types for the port 4 block
// assumes no other package
package p4m_pkg;
    // operating mode of the chip as seen by the port
    typedef enum logic [2:0] {
        P4M_ACTIVE    = 3'b000,
        P4M_SUBACTIVE = 3'b001,
        P4M_SLEEP     = 3'b010,
        P4M_SUBSLEEP  = 3'b011,
        P4M_WATCH     = 3'b100,
        P4M_STANDBY   = 3'b101
    } p4m_mode_t;
    // owner of one shared pin
    typedef enum logic [1:0] {
        P4M_OWN_GPIO   = 2'b00,
        P4M_OWN_SER_OUT = 2'b01,
        P4M_OWN_SER_IN = 2'b10
    } p4m_owner_t;
endpackage : p4m_pkg

// *** rtl/p4m_sync.sv ***
// two-flop synchroniser for one pin level
// assumes d comes from outside the ref_clk domain
`timescale 1ns/100ps
`include "p4m_map.svh"
module p4m_sync (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // level in and out
    input  wire logic d,
    output logic      q
);
    logic meta_q;
    // first flop feeds only the second
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_q <= `P4M_SYNC_RST;
            q      <= `P4M_SYNC_RST;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : p4m_sync

// *** rtl/p4m_pinmux.sv ***
// pin owner selection for the three shared pins
// assumes serial control bits are registers of the same clock
`timescale 1ns/100ps
`include "p4m_map.svh"
module p4m_pinmux
    import p4m_pkg::*;
(
    // serial control bits
    input  wire logic       serial_b_tx_pin_enable,
    input  wire logic       transmit_enable_bit,
    input  wire logic       receive_enable_bit,
    input  wire logic       clock_select_high,
    input  wire logic       clock_select_low,
    input  wire logic       sync_mode_bit,
    // owner per pin
    output p4m_owner_t      owner [3]
);
    // transmit pin, receive pin, clock pin
    always_comb begin
        owner[`P4M_BIT_TXD] = (serial_b_tx_pin_enable && transmit_enable_bit)
                              ? P4M_OWN_SER_OUT : P4M_OWN_GPIO; // R12
        owner[`P4M_BIT_RXD] = receive_enable_bit ? P4M_OWN_SER_IN : P4M_OWN_GPIO; // R13
        if (clock_select_high)
            owner[`P4M_BIT_SCK] = P4M_OWN_SER_IN; // R14
        else if (clock_select_low || sync_mode_bit)
            owner[`P4M_BIT_SCK] = P4M_OWN_SER_OUT; // R14
        else
            owner[`P4M_BIT_SCK] = P4M_OWN_GPIO;
    end
endmodule : p4m_pinmux

// *** rtl/p4m_port.sv ***
// Function
// R1 - the port has three two-way pins and one input-only internal line.
// R2 - the internal line comes only from the on-chip decoder interrupt, never from a pin.
// R3 - the data register is 8 bits, bits 2..0 writable, bit 3 read-only, 7..4 unused.
// R4 - a port read returns the latch for pins whose direction bit is 1.
// R5 - a port read returns the live pin for pins whose direction bit is 0.
// R6 - reset loads the data register with f8.
// R7 - a direction bit of 1 drives the pin, 0 makes it an input.
// R8 - direction and data act only while the pin is general purpose, else serial owns it.
// R9 - reset loads the direction register with f8, all pins inputs.
// R10 - the direction register is write-only and reads as all ones.
// R11 - the internal line is a port input when the select bit is 0, interrupt zero when 1. The code reads it at bit 3 for either select value.
// R12 - pin 2 is serial transmit only when pin-enable and transmit-enable are both 1.
// R13 - pin 1 is serial receive when receive-enable is 1, else general purpose.
// R14 - pin 0 is clock in when select-high, clock out when select-low or sync, else gpio.
// R15 - internal reads high at reset, pins float at reset and standby, hold in sleeps.
// R16 - writes to unused bits and read-only bit 3 are ignored.
//
// port 4 register pair, pin muxing onto the second serial channel, mode pin states
// assumes a single 100 MHz clock, registers reached over a plain strobe port
`timescale 1ns/100ps
`include "p4m_map.svh"
module p4m_port
    import p4m_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // register port
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // chip mode and control bits from other blocks
    input  wire p4m_mode_t   chip_mode,
    input  wire logic        ext_interrupt_zero_select,
    input  wire logic        serial_b_tx_pin_enable,
    input  wire logic        transmit_enable_bit,
    input  wire logic        receive_enable_bit,
    input  wire logic        clock_select_high,
    input  wire logic        clock_select_low,
    input  wire logic        sync_mode_bit,
    // decoder interrupt line, internal
    input  wire logic        decoder_irq_n,
    // two-way pins
    input  wire logic [2:0]  pin_in,
    output logic      [2:0]  pin_out,
    output logic      [2:0]  pin_oe,
    // serial channel side and interrupt zero line
    input  wire logic        serial_b_transmit_out,
    input  wire logic        serial_b_clock_out,
    output logic             serial_b_receive_in,
    output logic             serial_b_clock_pin,
    output logic             ext_interrupt_zero_select_n
);
    logic [7:0]  data_q;
    logic [7:0]  dir_q;
    logic [2:0]  pin_sync;
    logic        dec_sync;
    logic        port_hit_q;
    logic [7:0]  port_view;
    logic        hold;
    logic        float_all;
    p4m_owner_t  owner [3];

    // pin levels and decoder line enter through synchronisers
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            p4m_sync u_sync (
                .ref_clk (ref_clk),
                .rst     (rst),
                .d       (pin_in[gi]),
                .q       (pin_sync[gi])
            );
        end
    endgenerate

    // internal line taken only from the decoder
    p4m_sync u_dec_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .d       (decoder_irq_n), // R2
        .q       (dec_sync)
    );

    // owner of each shared pin
    p4m_pinmux u_mux (
        .serial_b_tx_pin_enable (serial_b_tx_pin_enable),
        .transmit_enable_bit    (transmit_enable_bit),
        .receive_enable_bit     (receive_enable_bit),
        .clock_select_high      (clock_select_high),
        .clock_select_low       (clock_select_low),
        .sync_mode_bit          (sync_mode_bit),
        .owner                  (owner)
    );

    // mode decode: hold in sleeps, float in standby
    assign hold      = (chip_mode == P4M_SLEEP) || (chip_mode == P4M_SUBSLEEP)
                    || (chip_mode == P4M_WATCH); // R15
    assign float_all = (chip_mode == P4M_STANDBY); // R15

    // data register, only bits 2..0 take writes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            data_q <= `P4M_RST_DATA; // R6
        end else if (reg_wr && reg_addr == `P4M_ADDR_DATA) begin
            data_q <= `P4M_FIXED_MASK | (reg_wdata & `P4M_RW_MASK); // R3 R16
        end
    end

    // direction register, write-only
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dir_q <= `P4M_RST_DIR; // R9
        end else if (reg_wr && reg_addr == `P4M_ADDR_DIR) begin
            dir_q <= `P4M_FIXED_MASK | (reg_wdata & `P4M_RW_MASK); // R16
        end
    end

    // port view: latch for outputs, pin for inputs, bit 3 internal line
    always_comb begin
        port_view = `P4M_FIXED_MASK;
        for (int i = 0; i < 3; i++) begin
            port_view[i] = dir_q[i] ? data_q[i] : pin_sync[i]; // R4 R5
        end
        port_view[`P4M_BIT_INTERNAL] = dec_sync; // R1 R11
    end

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd && reg_addr == `P4M_ADDR_DATA) begin
            reg_rdata <= port_view;
        end else if (reg_rd && reg_addr == `P4M_ADDR_DIR) begin
            reg_rdata <= `P4M_DIR_READ; // R10
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // pin drive per owner, frozen in sleep modes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_oe  <= 3'h0; // R15
            pin_out <= 3'h0;
        end else if (float_all) begin
            pin_oe  <= 3'h0; // R15
        end else if (!hold) begin
            for (int i = 0; i < 3; i++) begin
                if (owner[i] == P4M_OWN_GPIO) begin
                    pin_oe[i]  <= dir_q[i]; // R7 R8
                    pin_out[i] <= data_q[i];
                end else if (owner[i] == P4M_OWN_SER_OUT) begin
                    pin_oe[i]  <= 1'b1; // R8
                    pin_out[i] <= (i == `P4M_BIT_TXD) ? serial_b_transmit_out
                                                      : serial_b_clock_out;
                end else begin
                    pin_oe[i]  <= 1'b0;
                    pin_out[i] <= 1'b0;
                end
            end
        end
    end

    // serial inputs and interrupt line toward other blocks
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            serial_b_receive_in <= 1'b1;
            serial_b_clock_pin  <= 1'b1;
            ext_interrupt_zero_select_n              <= 1'b1;
        end else if (!hold) begin
            serial_b_receive_in <= (owner[`P4M_BIT_RXD] == P4M_OWN_SER_IN)
                                   ? pin_sync[`P4M_BIT_RXD] : 1'b1; // R13
            serial_b_clock_pin  <= (owner[`P4M_BIT_SCK] == P4M_OWN_SER_IN)
                                   ? pin_sync[`P4M_BIT_SCK] : 1'b1; // R14
            ext_interrupt_zero_select_n              <= ext_interrupt_zero_select ? dec_sync : 1'b1; // R11
        end
    end

    // checks
    property p_dir_reads_ones;
        @(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == `P4M_ADDR_DIR |=> reg_rdata == 8'hff;
    endproperty
    a_dir_reads_ones: assert property (p_dir_reads_ones) else $error("dir read not ones"); // R10

    property p_data_fixed;
        @(posedge ref_clk) disable iff (rst)
        data_q[7:3] == 5'h1f && dir_q[7:3] == 5'h1f;
    endproperty
    a_data_fixed: assert property (p_data_fixed) else $error("fixed bits changed"); // R16

    property p_wr_data;
        @(posedge ref_clk) disable iff (rst)
        reg_wr && reg_addr == `P4M_ADDR_DATA |=> data_q[2:0] == $past(reg_wdata[2:0]);
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("data write lost"); // R3

    property p_reset_vals;
        @(posedge ref_clk) $past(rst) |-> data_q == 8'hf8 && dir_q == 8'hf8 && pin_oe == 3'h0;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset values"); // R6 R9

    property p_standby_float;
        @(posedge ref_clk) disable iff (rst)
        chip_mode == P4M_STANDBY |=> pin_oe == 3'h0;
    endproperty
    a_standby_float: assert property (p_standby_float) else $error("pins driven in standby"); // R15

    property p_gpio_drive;
        @(posedge ref_clk) disable iff (rst)
        chip_mode == P4M_ACTIVE && owner[2] == P4M_OWN_GPIO |=> pin_oe[2] == $past(dir_q[2]);
    endproperty
    a_gpio_drive: assert property (p_gpio_drive) else $error("gpio direction wrong"); // R7

    property p_txd_drive;
        @(posedge ref_clk) disable iff (rst)
        chip_mode == P4M_ACTIVE && serial_b_tx_pin_enable && transmit_enable_bit
        |=> pin_oe[2] && pin_out[2] == $past(serial_b_transmit_out);
    endproperty
    a_txd_drive: assert property (p_txd_drive) else $error("transmit not on pin"); // R12

    property p_rx_float;
        @(posedge ref_clk) disable iff (rst)
        chip_mode == P4M_ACTIVE && receive_enable_bit |=> !pin_oe[1];
    endproperty
    a_rx_float: assert property (p_rx_float) else $error("receive pin driven"); // R13

    property p_out_read;
        @(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == `P4M_ADDR_DATA && dir_q[0] |=> reg_rdata[0] == $past(data_q[0]);
    endproperty
    a_out_read: assert property (p_out_read) else $error("latch not read"); // R4
endmodule : p4m_port

// *** tb/p4m_far.sv ***
// far side of port 4: external pin drivers and the decoder line
// assumes the bench picks the levels the far side presents
`timescale 1ns/100ps
module p4m_far (
    // device drive
    input  wire logic [2:0] pin_out,
    input  wire logic [2:0] pin_oe,
    // far side levels
    input  wire logic [2:0] ext_lvl,
    input  wire logic       dec_lvl,
    // resolved levels
    output logic      [2:0] pin_in,
    output logic            decoder_irq_n
);
    // device wins where it drives, else the outside part drives
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_lvl[i];
        end
    end
    // decoder feeds only the internal line
    assign decoder_irq_n = dec_lvl;
endmodule : p4m_far

// *** tb/port4_io_with_serial_pin_mux_bench.sv ***
// bench for the port 4 block: register port, pin mux, mode states
// assumes p4m_far stands for the outside parts
`timescale 1ns/100ps
`include "p4m_map.svh"
module port4_io_with_serial_pin_mux_bench;
    import p4m_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    p4m_mode_t chip_mode = P4M_ACTIVE;
    logic irq_sel = 1'b0;
    logic [5:0] ser = 6'h00;
    logic [2:0] ext_lvl = 3'h5;
    logic dec_lvl = 1'b1;
    logic tx_src = 1'b0;
    logic ck_src = 1'b0;
    logic [2:0] pin_in, pin_out, pin_oe;
    logic dec_n, rx_obs, sck_obs, ext_interrupt_zero_select_n;
    int err_total = 0;
    int tests_run = 0;
    int seed = 32'h7870;
    // clock
    always #5 ref_clk = ~ref_clk;
    p4m_port u_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .chip_mode(chip_mode), .ext_interrupt_zero_select(irq_sel),
        .serial_b_tx_pin_enable(ser[5]), .transmit_enable_bit(ser[4]),
        .receive_enable_bit(ser[3]), .clock_select_high(ser[2]),
        .clock_select_low(ser[1]), .sync_mode_bit(ser[0]), .decoder_irq_n(dec_n),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .serial_b_transmit_out(tx_src), .serial_b_clock_out(ck_src),
        .serial_b_receive_in(rx_obs), .serial_b_clock_pin(sck_obs), .ext_interrupt_zero_select_n(ext_interrupt_zero_select_n));
    p4m_far u_far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
        .dec_lvl(dec_lvl), .pin_in(pin_in), .decoder_irq_n(dec_n));
    // expected port read
    function automatic logic [7:0] exp_rd(logic [2:0] dir, logic [2:0] dat);
        return {4'hf, dec_lvl, (dir & dat) | (~dir & ext_lvl)};
    endfunction : exp_rd
    // expected drive enables, s = pin en, tx en, rx en, ck high, ck low, sync
    function automatic logic [2:0] exp_oe(logic [2:0] dir, logic [5:0] s);
        return {(s[5] & s[4]) | dir[2], ~s[3] & dir[1], ~s[2] & (s[1] | s[0] | dir[0])};
    endfunction : exp_oe
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
            err_total++;
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : idle
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    task automatic results;
        if (err_total == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results
    // hang guard
    initial begin
        #900us;
        err_total++;
        results();
    end
    // main sequence
    initial begin
        logic [7:0] v;
        logic [7:0] u;
        logic [2:0] dir;
        logic [2:0] dat;
        p4m_mode_t slp [3];
        slp = '{P4M_SLEEP, P4M_SUBSLEEP, P4M_WATCH};
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        idle(3);
        chk({5'h00, pin_oe}, 8'h00);
        chk({7'h00, ext_interrupt_zero_select_n}, 8'h01);
        rd(`P4M_ADDR_DIR, v);
        chk(v, 8'hff);
        rd(16'hffd8, v);
        chk(v, 8'h00);
        wr(`P4M_ADDR_DIR, 8'h07);
        rd(`P4M_ADDR_DATA, v);
        chk(v, exp_rd(3'h7, 3'h0));
        // random direction, data and outside levels
        for (int i = 0; i < 24; i++) begin
            dir = 3'($random(seed));
            dat = 3'($random(seed));
            v = 8'($random(seed));
            u = 8'($random(seed));
            if (i < 2) dir = {3{i[0]}};
            @(posedge ref_clk);
            ext_lvl <= u[2:0];
            dec_lvl <= u[3];
            irq_sel <= u[4];
            wr(`P4M_ADDR_DIR, {v[7:3], dir});
            wr(`P4M_ADDR_DATA, {~v[7:3], dat});
            idle(4);
            chk({5'h00, pin_oe}, {5'h00, dir});
            chk({5'h00, pin_out & dir}, {5'h00, dat & dir});
            chk({7'h00, ext_interrupt_zero_select_n}, {7'h00, irq_sel ? dec_lvl : 1'b1});
            rd(`P4M_ADDR_DATA, u);
            chk(u, exp_rd(dir, dat));
            rd(`P4M_ADDR_DIR, u);
            chk(u, 8'hff);
        end
        // every serial control combination over both direction settings
        for (int k = 0; k < 128; k++) begin
            dir = {3{k[6]}};
            if (k[5:0] == 6'h00) wr(`P4M_ADDR_DIR, {5'h1f, dir});
            u = 8'($random(seed));
            @(posedge ref_clk);
            ser <= k[5:0];
            ext_lvl <= u[2:0];
            tx_src <= u[3];
            ck_src <= u[4];
            idle(4);
            chk({5'h00, pin_oe}, {5'h00, exp_oe(dir, ser)});
            if (ser[5] & ser[4]) chk({7'h00, pin_out[2]}, {7'h00, tx_src});
            if (~ser[2] & (ser[1] | ser[0])) chk({7'h00, pin_out[0]}, {7'h00, ck_src});
            chk({7'h00, rx_obs}, {7'h00, ser[3] ? ext_lvl[1] : 1'b1});
            chk({7'h00, sck_obs}, {7'h00, ser[2] ? ext_lvl[0] : 1'b1});
        end
        // standby floats, sleep modes hold the pins
        @(posedge ref_clk);
        ser <= 6'h00;
        wr(`P4M_ADDR_DATA, 8'h05);
        @(posedge ref_clk);
        chip_mode <= P4M_STANDBY;
        idle(4);
        chk({5'h00, pin_oe}, 8'h00);
        for (int m = 0; m < 3; m++) begin
            @(posedge ref_clk);
            chip_mode <= P4M_ACTIVE;
            wr(`P4M_ADDR_DATA, 8'h05);
            idle(4);
            chip_mode <= slp[m];
            wr(`P4M_ADDR_DATA, 8'h02);
            idle(4);
            chk({2'h0, pin_oe, pin_out}, 8'h3d);
        end
        @(posedge ref_clk);
        chip_mode <= P4M_ACTIVE;
        idle(4);
        chk({2'h0, pin_oe, pin_out}, 8'h3a);
        // reset in mid run
        @(posedge ref_clk);
        rst <= 1'b1;
        idle(2);
        rst <= 1'b0;
        idle(3);
        chk({5'h00, pin_oe}, 8'h00);
        wr(`P4M_ADDR_DIR, 8'h07);
        rd(`P4M_ADDR_DATA, v);
        chk(v, exp_rd(3'h7, 3'h0));
        results();
    end
endmodule : port4_io_with_serial_pin_mux_bench
